// ==== core/adc_sample_convert_control.sv ====
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
// Notes on behaviour
// - Resolution bit set gives 12-bit single channel; clear gives 10-bit four channels.
// - Module-on bit enables the converter; clear switches it off.
// - Idle-stop bit set halts the module while the device idles.
// - 10-bit results formatted as integer, signed integer, fraction, signed fraction.
// - 12-bit results use the same four format codes, aligned to twelve bits.
// - Trigger source picks what ends sampling: software, pin, timer, PWM, counter.
// - Auto-convert samples for auto-sample-time conversion clock periods, 0 to 31.
// - Conversion clock period is system clock times divider plus one; divider codes above 63 act as 63.
// - Channel count selects one, two or four channels to convert.
// - Simultaneous bit samples all selected channels at once, else in sequence.
// - In 12-bit mode the simultaneous bit reads zero.
// - Auto-start restarts sampling right after each conversion finishes.
// - Sample bit set means acquiring; software writes one to start.
// - Software trigger clears sample bit by write; other sources clear in hardware.
// - Done bit set on completion, cleared when a new conversion starts.
// - Software may only clear done; clearing never disturbs a conversion.
// - Results land in a sixteen-word readable buffer.
// - Input select covers analog inputs 0 through 12.
// - 12-bit mode has one sample-and-hold, so no simultaneous sampling.
// - Unimplemented control bits ignore writes and read zero.
module adc_sample_convert_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic idleMode,
    input wire logic extIrqPinZero,
    input wire logic timerThreeCompare,
    input wire logic pwmOneInterval,
    input wire logic pwmTwoInterval,
    output adc_pkg::conv_req_t convReq,
    input wire adc_pkg::conv_rsp_t convRsp
);
    adc_pkg::state_t s_ff;
    adc_pkg::state_t nxt_s;
    logic halted;
    logic simEff;
    logic [1:0] lastChan;
    logic [7:0] effDiv;
    logic tadTick;
    logic extEdge;
    logic trigger;
    logic swSampSet;
    logic swSampClr;
    logic swDoneClr;
    logic addrPhase;
    logic [15:0] fmtWord;
    logic [3:0] acquire;

    // Control one as software sees it; unimplemented bits stay zero
    function automatic logic [15:0] ctl_one_view(input adc_pkg::state_t v);
        logic [15:0] c;
        c = 16'h0000;
        c[adc_pkg::BIT_MODULE_ON] = v.ctl.moduleOn;
        c[adc_pkg::BIT_IDLE_STOP] = v.ctl.idleStop;
        c[adc_pkg::BIT_RESOLUTION] = v.ctl.res12;
        c[adc_pkg::FORMAT_LO +: 2] = v.ctl.outputFormat;
        c[adc_pkg::TRIGGER_LO +: 3] = v.ctl.triggerSource;
        c[adc_pkg::BIT_SIMULTANEOUS] = v.ctl.simSample & ~v.ctl.res12;
        c[adc_pkg::BIT_AUTO_START] = v.ctl.autoStart;
        c[adc_pkg::BIT_SAMPLE] = (v.phase == adc_pkg::ST_SAMPLE);
        c[adc_pkg::BIT_DONE] = v.ctl.done;
        return c;
    endfunction

    // Read multiplexer; unmapped offsets read zero
    function automatic logic [31:0] read_word(input adc_pkg::state_t v, input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a[7:6] == adc_pkg::RESULT_PAGE) begin
            w[15:0] = v.results[a[5:2]];
        end else begin
            case (a)
                adc_pkg::OFS_CONTROL_ONE: w[15:0] = ctl_one_view(v);
                adc_pkg::OFS_CONTROL_TWO: begin
                    w[adc_pkg::CHANNEL_COUNT_LO +: 2] = v.ctl.res12 ? 2'h0 : v.ctl.channelCount;
                end
                adc_pkg::OFS_CONTROL_THREE: begin
                    w[adc_pkg::SAMPLE_TIME_LO +: 5] = v.ctl.sampleTime;
                    w[adc_pkg::DIVIDER_LO +: 8] = v.ctl.clockDivider;
                end
                adc_pkg::OFS_INPUT_SELECT: w[adc_pkg::INPUT_SEL_LO +: 4] = v.ctl.inputSel;
                default: w = 32'h0000_0000;
            endcase
        end
        return w;
    endfunction

    result_formatter u_fmt (
        .raw(convRsp.result),
        .res12(s_ff.ctl.res12),
        .outputFormat(s_ff.ctl.outputFormat),
        .word(fmtWord)
    );

    // Mode decode shared by the sequencer and the hold outputs
    assign halted = s_ff.ctl.idleStop & idleMode;
    assign simEff = s_ff.ctl.simSample & ~s_ff.ctl.res12;
    assign lastChan = s_ff.ctl.res12 ? 2'h0 :
        (s_ff.ctl.channelCount[1] ? adc_pkg::LAST_CHANNEL : {1'b0, s_ff.ctl.channelCount[0]});
    assign effDiv = (s_ff.ctl.clockDivider >= adc_pkg::DIVIDER_LIMIT) ?
        adc_pkg::DIVIDER_MAX : s_ff.ctl.clockDivider;
    assign tadTick = (s_ff.tadCnt >= effDiv);
    // Only the second and third sync stages are looked at
    assign extEdge = s_ff.extSync[1] & ~s_ff.extSync[2];
    assign addrPhase = hsel & hready & htrans[1];

    // Trigger select; reserved codes never end sampling
    always_comb begin
        unique case (s_ff.ctl.triggerSource)
            adc_pkg::TRIG_SOFTWARE: trigger = swSampClr;
            adc_pkg::TRIG_EXT_PIN: trigger = extEdge;
            adc_pkg::TRIG_TIMER_THREE: trigger = timerThreeCompare;
            adc_pkg::TRIG_PWM_ONE: trigger = pwmOneInterval;
            adc_pkg::TRIG_PWM_TWO: trigger = pwmTwoInterval;
            adc_pkg::TRIG_AUTO: trigger = (s_ff.samCnt == s_ff.ctl.sampleTime);
            default: trigger = 1'b0;
        endcase
    end

    // Software strobes decoded in the data phase of a control one write
    always_comb begin
        swSampSet = 1'b0;
        swSampClr = 1'b0;
        swDoneClr = 1'b0;
        if (s_ff.apWrite && s_ff.apAddr == adc_pkg::OFS_CONTROL_ONE) begin
            swSampSet = hwdata[adc_pkg::BIT_SAMPLE] & ~s_ff.ctl.autoStart;
            swSampClr = ~hwdata[adc_pkg::BIT_SAMPLE];
            swDoneClr = ~hwdata[adc_pkg::BIT_DONE];
        end
    end

    // Whole next state: register writes, sequencer, bus read data
    always_comb begin
        nxt_s = s_ff;
        nxt_s.convStart = 1'b0;
        nxt_s.extSync = {s_ff.extSync[1:0], extIrqPinZero};
        if (s_ff.apWrite) begin
            case (s_ff.apAddr)
                adc_pkg::OFS_CONTROL_ONE: begin
                    nxt_s.ctl.moduleOn = hwdata[adc_pkg::BIT_MODULE_ON];
                    nxt_s.ctl.idleStop = hwdata[adc_pkg::BIT_IDLE_STOP];
                    // Resolution is frozen while on; the mux would glitch mid-frame
                    if (!s_ff.ctl.moduleOn) begin
                        nxt_s.ctl.res12 = hwdata[adc_pkg::BIT_RESOLUTION];
                    end
                    nxt_s.ctl.outputFormat = hwdata[adc_pkg::FORMAT_LO +: 2];
                    nxt_s.ctl.triggerSource = hwdata[adc_pkg::TRIGGER_LO +: 3];
                    nxt_s.ctl.simSample = hwdata[adc_pkg::BIT_SIMULTANEOUS];
                    nxt_s.ctl.autoStart = hwdata[adc_pkg::BIT_AUTO_START];
                end
                adc_pkg::OFS_CONTROL_TWO: begin
                    nxt_s.ctl.channelCount = hwdata[adc_pkg::CHANNEL_COUNT_LO +: 2];
                end
                adc_pkg::OFS_CONTROL_THREE: begin
                    nxt_s.ctl.sampleTime = hwdata[adc_pkg::SAMPLE_TIME_LO +: 5];
                    nxt_s.ctl.clockDivider = hwdata[adc_pkg::DIVIDER_LO +: 8];
                end
                adc_pkg::OFS_INPUT_SELECT: begin
                    // Codes past the last analog input are dropped
                    if (hwdata[adc_pkg::INPUT_SEL_LO +: 4] <= adc_pkg::LAST_ANALOG_INPUT) begin
                        nxt_s.ctl.inputSel = hwdata[adc_pkg::INPUT_SEL_LO +: 4];
                    end
                end
                default: nxt_s.ctl = s_ff.ctl;
            endcase
        end
        // Clear first so a same-cycle hardware set wins
        if (swDoneClr) begin
            nxt_s.ctl.done = 1'b0;
        end
        if (!s_ff.ctl.moduleOn) begin
            nxt_s.phase = adc_pkg::ST_HOLD;
            nxt_s.tadCnt = 8'h00;
            nxt_s.samCnt = 5'h00;
            nxt_s.curChan = 2'h0;
        end else if (!halted) begin
            nxt_s.tadCnt = tadTick ? 8'h00 : s_ff.tadCnt + 8'h01;
            unique case (s_ff.phase)
                adc_pkg::ST_HOLD: begin
                    nxt_s.samCnt = 5'h00;
                    if (swSampSet || s_ff.ctl.autoStart) begin
                        nxt_s.phase = adc_pkg::ST_SAMPLE;
                    end
                end
                adc_pkg::ST_SAMPLE: begin
                    if (trigger) begin
                        nxt_s.phase = adc_pkg::ST_START;
                        nxt_s.curChan = 2'h0;
                        nxt_s.ctl.done = 1'b0;
                    end else if (tadTick) begin
                        nxt_s.samCnt = s_ff.samCnt + 5'h01;
                    end
                end
                adc_pkg::ST_START: begin
                    nxt_s.convStart = 1'b1;
                    nxt_s.phase = adc_pkg::ST_WAIT;
                end
                adc_pkg::ST_WAIT: begin
                    if (convRsp.done) begin
                        nxt_s.results[s_ff.wrPtr] = fmtWord;
                        nxt_s.wrPtr = s_ff.wrPtr + 4'h1;
                        if (s_ff.curChan == lastChan) begin
                            nxt_s.phase = adc_pkg::ST_FINISH;
                        end else begin
                            nxt_s.curChan = s_ff.curChan + 2'h1;
                            nxt_s.phase = adc_pkg::ST_START;
                        end
                    end
                end
                adc_pkg::ST_FINISH: begin
                    nxt_s.ctl.done = 1'b1;
                    nxt_s.samCnt = 5'h00;
                    nxt_s.phase = s_ff.ctl.autoStart ? adc_pkg::ST_SAMPLE : adc_pkg::ST_HOLD;
                end
            endcase
        end
        // Address phase capture; read data is taken from the settled next state
        nxt_s.apWrite = addrPhase & hwrite;
        nxt_s.apAddr = haddr[7:0];
        if (addrPhase && !hwrite) begin
            nxt_s.rdData = read_word(nxt_s, haddr[7:0]);
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Sequential mode keeps later channels acquiring until their turn
    for (genvar k = 0; k < 4; k++) begin : g_hold
        assign acquire[k] = s_ff.ctl.moduleOn && (2'(k) <= lastChan) &&
            ((s_ff.phase == adc_pkg::ST_SAMPLE) ||
             (!simEff && 2'(k) > s_ff.curChan &&
              (s_ff.phase == adc_pkg::ST_START || s_ff.phase == adc_pkg::ST_WAIT)));
    end

    assign convReq = '{start: s_ff.convStart, channel: s_ff.curChan,
        inputSel: s_ff.ctl.inputSel, res12: s_ff.ctl.res12, acquire: acquire};
    assign hrdata = s_ff.rdData;
    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_off_holds;
        !s_ff.ctl.moduleOn |=> s_ff.phase == adc_pkg::ST_HOLD && convReq.acquire == 4'h0;
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("off module left hold");

    property p_idle_freeze;
        s_ff.ctl.moduleOn && halted && $past(s_ff.ctl.moduleOn) ##1 halted |-> $stable(s_ff.phase);
    endproperty
    a_idle_freeze: assert property (p_idle_freeze) else $error("phase moved in idle");

    property p_sim_reads_zero;
        addrPhase && !hwrite && haddr[7:0] == adc_pkg::OFS_CONTROL_ONE && nxt_s.ctl.res12
            |=> !hrdata[adc_pkg::BIT_SIMULTANEOUS];
    endproperty
    a_sim_reads_zero: assert property (p_sim_reads_zero) else $error("simultaneous bit read one");

    property p_done_on_finish;
        s_ff.phase == adc_pkg::ST_FINISH && !halted && s_ff.ctl.moduleOn |=> s_ff.ctl.done;
    endproperty
    a_done_on_finish: assert property (p_done_on_finish) else $error("done not set");

    property p_done_cleared_start;
        s_ff.phase == adc_pkg::ST_SAMPLE ##1 s_ff.phase == adc_pkg::ST_START |-> !s_ff.ctl.done;
    endproperty
    a_done_cleared_start: assert property (p_done_cleared_start) else $error("done stuck");

    property p_autostart;
        s_ff.phase == adc_pkg::ST_FINISH && s_ff.ctl.autoStart && !halted && s_ff.ctl.moduleOn
            |=> s_ff.phase == adc_pkg::ST_SAMPLE ##0 (convReq.acquire[0] || !s_ff.ctl.moduleOn);
    endproperty
    a_autostart: assert property (p_autostart) else $error("auto-start missed");

    property p_auto_convert;
        s_ff.phase == adc_pkg::ST_SAMPLE && s_ff.ctl.moduleOn && !halted &&
            s_ff.ctl.triggerSource == adc_pkg::TRIG_AUTO &&
            s_ff.samCnt == s_ff.ctl.sampleTime |=> s_ff.phase == adc_pkg::ST_START ##1
            (convReq.start || !$past(s_ff.ctl.moduleOn) || $past(halted));
    endproperty
    a_auto_convert: assert property (p_auto_convert) else $error("counter trigger lost");

    property p_result_before_done;
        s_ff.phase == adc_pkg::ST_WAIT && convRsp.done && s_ff.ctl.moduleOn && !halted
            |=> s_ff.results[$past(s_ff.wrPtr)] == $past(fmtWord) && !s_ff.ctl.done;
    endproperty
    a_result_before_done: assert property (p_result_before_done) else $error("result not stored");

    property p_start_pulse;
        convReq.start |=> !convReq.start && s_ff.phase != adc_pkg::ST_START;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than a cycle");

    c_four_channels: cover property (s_ff.phase == adc_pkg::ST_FINISH && lastChan == 2'h3);
    c_twelve_bit: cover property (s_ff.ctl.res12 && s_ff.phase == adc_pkg::ST_FINISH);
    c_pin_trigger: cover property (extEdge && s_ff.phase == adc_pkg::ST_SAMPLE &&
        s_ff.ctl.triggerSource == adc_pkg::TRIG_EXT_PIN);
    c_done_race: cover property (swDoneClr && s_ff.phase == adc_pkg::ST_FINISH);
endmodule

// ==== core/adc_pkg.sv ====
package adc_pkg;
    // Register byte offsets on the AHB-Lite window
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFS_CONTROL_THREE = 8'h08;
    localparam logic [7:0] OFS_INPUT_SELECT = 8'h0C;
    localparam logic [1:0] RESULT_PAGE = 2'h1;
    localparam int ADDR_W = 8;

    // Control one field positions
    localparam int BIT_MODULE_ON = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_RESOLUTION = 10;
    localparam int FORMAT_LO = 8;
    localparam int TRIGGER_LO = 5;
    localparam int BIT_SIMULTANEOUS = 3;
    localparam int BIT_AUTO_START = 2;
    localparam int BIT_SAMPLE = 1;
    localparam int BIT_DONE = 0;
    // Control two, three and input select positions
    localparam int CHANNEL_COUNT_LO = 8;
    localparam int SAMPLE_TIME_LO = 8;
    localparam int DIVIDER_LO = 0;
    localparam int INPUT_SEL_LO = 0;

    // Trigger source codes
    localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
    localparam logic [2:0] TRIG_EXT_PIN = 3'h1;
    localparam logic [2:0] TRIG_TIMER_THREE = 3'h2;
    localparam logic [2:0] TRIG_PWM_ONE = 3'h3;
    localparam logic [2:0] TRIG_PWM_TWO = 3'h5;
    localparam logic [2:0] TRIG_AUTO = 3'h7;

    // Output format codes
    localparam logic [1:0] FMT_INTEGER = 2'h0;
    localparam logic [1:0] FMT_SIGNED_INT = 2'h1;
    localparam logic [1:0] FMT_FRACTION = 2'h2;
    localparam logic [1:0] FMT_SIGNED_FRAC = 2'h3;

    // Divider codes from 64 upward are reserved
    localparam logic [7:0] DIVIDER_LIMIT = 8'h40;
    localparam logic [7:0] DIVIDER_MAX = 8'h3F;
    localparam logic [3:0] LAST_ANALOG_INPUT = 4'hC;
    localparam logic [1:0] LAST_CHANNEL = 2'h3;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_START = 3'b010,
        ST_WAIT = 3'b011,
        ST_FINISH = 3'b100
    } phase_t;

    typedef struct packed {
        logic moduleOn;
        logic idleStop;
        logic res12;
        logic [1:0] outputFormat;
        logic [2:0] triggerSource;
        logic simSample;
        logic autoStart;
        logic done;
        logic [1:0] channelCount;
        logic [4:0] sampleTime;
        logic [7:0] clockDivider;
        logic [3:0] inputSel;
    } ctrl_t;

    // Request to the analog core
    typedef struct packed {
        logic start;
        logic [1:0] channel;
        logic [3:0] inputSel;
        logic res12;
        logic [3:0] acquire;
    } conv_req_t;

    // Answer from the analog core
    typedef struct packed {
        logic done;
        logic [11:0] result;
    } conv_rsp_t;

    typedef struct packed {
        ctrl_t ctl;
        phase_t phase;
        logic [1:0] curChan;
        logic [7:0] tadCnt;
        logic [4:0] samCnt;
        logic [3:0] wrPtr;
        logic [15:0][15:0] results;
        logic apWrite;
        logic [7:0] apAddr;
        logic [31:0] rdData;
        logic [2:0] extSync;
        logic convStart;
    } state_t;
endpackage

// ==== core/result_formatter.sv ====
`timescale 1ns/100ps
module result_formatter (
    input wire logic [11:0] raw,
    input wire logic res12,
    input wire logic [1:0] outputFormat,
    output logic [15:0] word
);
    logic [9:0] d10;
    logic [11:0] d12;

    assign d10 = raw[9:0];
    assign d12 = raw;

    // Sign bits are the inverted MSB, so mid-scale maps to zero
    always_comb begin
        word = 16'h0000;
        if (res12) begin
            unique case (outputFormat)
                adc_pkg::FMT_SIGNED_FRAC: word = {~d12[11], d12[10:0], 4'h0};
                adc_pkg::FMT_FRACTION: word = {d12, 4'h0};
                adc_pkg::FMT_SIGNED_INT: word = {{5{~d12[11]}}, d12[10:0]};
                adc_pkg::FMT_INTEGER: word = {4'h0, d12};
            endcase
        end else begin
            unique case (outputFormat)
                adc_pkg::FMT_SIGNED_FRAC: word = {~d10[9], d10[8:0], 6'h00};
                adc_pkg::FMT_FRACTION: word = {d10, 6'h00};
                adc_pkg::FMT_SIGNED_INT: word = {{7{~d10[9]}}, d10[8:0]};
                adc_pkg::FMT_INTEGER: word = {6'h00, d10};
            endcase
        end
    end
endmodule

// ==== bench/analog_core_model.sv ====
`timescale 1ns/100ps
module analog_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire adc_pkg::conv_req_t convReq,
    input wire logic [3:0] latency,
    input wire logic [11:0] codeBase,
    output adc_pkg::conv_rsp_t convRsp
);
    logic busy;
    logic [3:0] cnt;

    // One answer per start; result lines toggle junk outside the done cycle
    always @(posedge clk) begin
        convRsp.done <= 1'b0;
        convRsp.result <= ~convRsp.result;
        if (!rst_n) begin
            busy <= 1'b0;
            convRsp.result <= 12'h0A5;
        end else if (convReq.start) begin
            busy <= 1'b1;
            cnt <= latency;
        end else if (busy && cnt <= 4'h1) begin
            busy <= 1'b0;
            convRsp.done <= 1'b1;
            convRsp.result <= codeBase + 12'(convReq.channel); // Code tells channel apart
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic idleMode = 1'b0;
    logic [3:0] trig = 4'h0;
    logic [3:0] latency = 4'h1;
    logic [11:0] codeBase = 12'h000;
    logic [3:0] ptr = 4'h0;
    adc_pkg::conv_req_t convReq;
    adc_pkg::conv_rsp_t convRsp;
    int fails = 0;
    int checksDone = 0;
    int startCnt = 0;
    int cyc = 0;
    int lastStart = 0;
    int prevStart = 0;

    assign hready = hreadyout;
    always #4 clk = ~clk;

    adc_sample_convert_control i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .idleMode(idleMode),
        .extIrqPinZero(trig[0]), .timerThreeCompare(trig[1]), .pwmOneInterval(trig[2]),
        .pwmTwoInterval(trig[3]), .convReq(convReq), .convRsp(convRsp));
    analog_core_model i_core (.clk(clk), .rst_n(rst_n), .convReq(convReq),
        .latency(latency), .codeBase(codeBase), .convRsp(convRsp));

    // Log start pulses so sampling spans can be measured
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (convReq.start === 1'b1) begin
            startCnt <= startCnt + 1;
            prevStart <= lastStart;
            lastStart <= cyc;
        end
    end

    task automatic summarize();
        $display("checks=%0d errors=%0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Single AHB transfer; no wait-state count is assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask

    // Polls the done flag, bounded so a lost conversion cannot hang the run
    task automatic waitDone();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b0, 8'h00, 32'h0000_0000, q);
            n++;
        end while (q[0] !== 1'b1 && n < 200);
        chk({31'h0000_0000, q[0]}, 32'h0000_0001);
    endtask

    function automatic logic [15:0] fmt(logic [11:0] r, logic res, logic [1:0] f);
        case ({res, f})
            3'h0: return {6'h00, r[9:0]};
            3'h1: return {{7{~r[9]}}, r[8:0]};
            3'h2: return {r[9:0], 6'h00};
            3'h3: return {~r[9], r[8:0], 6'h00};
            3'h4: return {4'h0, r};
            3'h5: return {{5{~r[11]}}, r[10:0]};
            3'h6: return {r, 4'h0};
            default: return {~r[11], r[10:0], 4'h0};
        endcase
    endfunction

    task automatic resultChk(input logic [15:0] e);
        rdChk(8'h40 + {2'h0, ptr, 2'h0}, {16'h0000, e});
        ptr++;
    endtask

    task automatic pulse(input logic [3:0] m);
        trig <= m;
        @(posedge clk);
        trig <= 4'h0;
    endtask

    task automatic testRegs();
        rdChk(8'h00, 32'h0000_0000);
        rdChk(8'h08, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rdChk(8'h20, 32'h0000_0000);
        wr(8'h00, 32'hFFFF_7F18);
        rdChk(8'h00, 32'h0000_2700);
        wr(8'h04, 32'h0000_0300);
        rdChk(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0000);
        wr(8'h00, 32'h0000_2308);
        rdChk(8'h00, 32'h0000_2308);
        wr(8'h00, 32'h0000_8000);
        wr(8'h00, 32'h0000_8400);
        rdChk(8'h00, 32'h0000_8000);
        wr(8'h0C, 32'h0000_000C);
        wr(8'h0C, 32'h0000_000D);
        rdChk(8'h0C, 32'h0000_000C);
        wr(8'h00, 32'h0000_0000);
    endtask

    // Every format in both resolutions, software trigger
    task automatic testFormats();
        logic [31:0] c;
        wr(8'h04, 32'h0000_0000);
        for (int r = 0; r < 2; r++) begin
            wr(8'h00, {21'h00_0000, r[0], 10'h000});
            for (int f = 0; f < 4; f++) begin
                c = {16'h0000, 1'b1, 4'h0, r[0], f[1:0], 8'h00};
                codeBase <= f[0] ? 12'hA6B : 12'h55C;
                wr(8'h00, c);
                wr(8'h00, c | 32'h0000_0002);
                @(posedge clk);
                chk({31'h0000_0000, convReq.acquire[0]}, 32'h0000_0001);
                chk({31'h0000_0000, convReq.res12}, {31'h0000_0000, r[0]});
                wr(8'h00, c);
                waitDone();
                resultChk(fmt(codeBase, r[0], f[1:0]));
                wr(8'h00, c);
                wr(8'h00, c | 32'h0000_0001);
                rdChk(8'h00, c);
            end
        end
        wr(8'h00, 32'h0000_0000);
    endtask

    // Hardware sources, four channels in sequence; a foreign pulse must not trigger
    task automatic testTriggers();
        logic [2:0] srcs [4];
        logic [31:0] c;
        srcs = '{3'h1, 3'h2, 3'h3, 3'h5};
        latency <= 4'h5;
        codeBase <= 12'h1FE;
        wr(8'h04, 32'h0000_0200);
        wr(8'h00, 32'h0000_8000);
        for (int i = 0; i < 4; i++) begin
            c = {16'h0000, 8'h80, srcs[i], 5'h00};
            wr(8'h00, c | 32'h0000_0002);
            pulse(4'h1 << ((i + 1) % 4));
            repeat (6) @(posedge clk);
            rdChk(8'h00, c | 32'h0000_0002);
            chk({28'h000_0000, convReq.inputSel}, 32'h0000_000C);
            pulse(4'h1 << i);
            wr(8'h00, c);
            waitDone();
            for (int k = 0; k < 4; k++) resultChk(fmt(12'h1FE + 12'(k), 1'b0, 2'h0));
        end
    endtask

    task automatic gapOf(output int g);
        int n0;
        n0 = startCnt;
        for (int k = 0; k < 400 && startCnt < n0 + 3; k++) @(posedge clk);
        g = lastStart - prevStart;
    endtask

    // Auto-convert with auto-start; halted in idle only when idle-stop is set
    task automatic testAuto();
        int g1;
        int g2;
        int n0;
        latency <= 4'h2;
        idleMode <= 1'b1;
        wr(8'h08, 32'h0000_0302);
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_A0E4);
        n0 = startCnt;
        repeat (80) @(posedge clk);
        chk(startCnt - n0, 32'h0000_0000);
        idleMode <= 1'b0;
        gapOf(g1);
        wr(8'h08, 32'h0000_0502);
        gapOf(g2);
        chk(g2 - g1, 32'h0000_0006);
        // Idle-stop drops first, so a result in flight is never lost to a halt
        wr(8'h00, 32'h0000_80E4);
        idleMode <= 1'b1;
        n0 = startCnt;
        repeat (80) @(posedge clk);
        chk({31'h0000_0000, startCnt > n0}, 32'h0000_0001);
        wr(8'h00, 32'h0000_0000);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        testRegs();
        testFormats();
        testTriggers();
        testAuto();
        summarize();
    end

    // Whole run needs several hundred cycles; this cuts a hang short
    initial begin
        #400_000;
        fails++;
        summarize();
    end
endmodule
